// ---- shared/serial_port_irq_consts.svh ----
// Purpose: addresses, field positions, resets for the serial port irq block
// Assumes: AHB-Lite word access, 100 MHz ref_clk_in
// Notes: register addresses and field layout follow
`ifndef SERIAL_PORT_IRQ_CONSTS_SVH
`define SERIAL_PORT_IRQ_CONSTS_SVH
// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define SP_MODE_ADDR 32'h40064000
`define SP_STATUS_ADDR 32'h40064008
`define SP_ENSET_ADDR 32'h4006400c
`define SP_ENCLR_ADDR 32'h40064010
// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define SP_FLAG_W 17
`define SP_BIT_NOISE 15
`define SP_BIT_AUTOBAUD_ERROR_FLAG 16
`define SP_MODE_SYNC 0
`define SP_MODE_ABD 1
`define SP_EN_MASK 17'h1f96d
`define SP_W1C_MASK 17'h1f920
`define SP_EN_RESET 17'h00000
`define SP_MODE_RESET 2'h0
`define SP_BRG_LIMIT 16'hffff
`endif

// ---- shared/serial_port_irq_pkg.sv ----
// Purpose: types shared by the serial port irq block and its bench
// Assumes: nothing beyond plain SystemVerilog
// Notes: event fields are levels or one-cycle pulses from the port core
package serial_port_irq_pkg;
  // ----------------------------------------------------------------
  // event inputs from the rest of the port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic parity_err;
    logic framing_err;
    logic start_seen;
    logic break_change;
    logic rx_break;
    logic overrun;
    logic tx_disabled;
    logic cts_change;
    logic cts_level;
    logic tx_idle;
    logic tx_ready;
    logic rx_idle;
    logic rx_ready;
  } port_events_t;
  typedef struct packed {
    logic autobaud_en;
    logic sync_mode;
  } port_mode_t;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
  } addr_phase_t;
  typedef enum logic [1:0] {
    BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE
  } bus_state_t;
  typedef enum logic [1:0] {ABD_IDLE, ABD_COUNT, ABD_OVER} abd_state_t;
endpackage

// ---- tb/serial_port_irq_flags_enables_assertions.sv ----
// Purpose: port-level checks for the serial port irq block
// Assumes: one clock, sync active-high reset
// Notes: flags and enables are internal, so these watch bus and sampling
`timescale 1ns/100ps
module serial_port_irq_checker #(
  parameter logic [15:0] BRG_LIMIT = 16'hffff
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [2:0] rx_samples_in,
  input wire logic rx_samples_valid_in,
  input wire logic rx_bit_out,
  input wire logic rx_bit_valid_out,
  input wire logic sync_mode_out,
  input wire logic [15:0] abd_count_out,
  input wire logic irq_out
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire taken = hsel_in && htrans_in[1] && hready_in;
  function automatic logic maj(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction
  function automatic logic mid(input logic [2:0] s);
    return s[1];
  endfunction
  a_read_wait: assert property (taken && !hwrite_in |=>
    !hreadyout_out ##1 hreadyout_out) else $error("read wait wrong");
  a_write_nowait: assert property (taken && hwrite_in |=> hreadyout_out)
    else $error("write stalled");
  a_resp_okay: assert property (hresp_out == 1'b0) else $error("not okay");
  a_rx_majority: assert property (
    rx_samples_valid_in && !sync_mode_out |=> rx_bit_valid_out &&
    rx_bit_out == maj($past(rx_samples_in))) else $error("bad majority");
  a_sync_center: assert property (
    rx_samples_valid_in && sync_mode_out |=>
    rx_bit_out == mid($past(rx_samples_in))) else $error("bad sync bit");
  a_bit_hold: assert property (
    !rx_samples_valid_in |=> !rx_bit_valid_out && $stable(rx_bit_out))
    else $error("rx bit moved");
  a_irq_reset: assert property (disable iff (1'b0)
    rst_in |=> !irq_out) else $error("irq after reset");
  a_upper_zero: assert property (hrdata_out[31:17] == 15'h0000)
    else $error("upper read bits set");
  a_abd_bound: assert property (abd_count_out <= BRG_LIMIT)
    else $error("count past limit");
  c_read: cover property (taken && !hwrite_in);
  c_noise: cover property (rx_samples_valid_in && (|rx_samples_in)
    && !(&rx_samples_in));
  c_irq: cover property ($rose(irq_out));
endmodule
bind serial_port_irq_flags_enables serial_port_irq_checker #(
  .BRG_LIMIT(BRG_LIMIT)) serial_port_irq_checker_i (.ref_clk_in, .rst_in,
  .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out,
  .hreadyout_out, .hresp_out, .rx_samples_in, .rx_samples_valid_in,
  .rx_bit_out, .rx_bit_valid_out, .sync_mode_out, .abd_count_out,
  .irq_out);

// ---- tb/test_serial_port_irq_flags_enables.sv ----
// Purpose: register and irq scenarios for the serial port irq block
// Assumes: short baud limit so autobaud time-out comes quickly
// Notes: bus data sampled at the ready edge through rdy_s and rd_s
`timescale 1ns/100ps
`include "serial_port_irq_consts.svh"
module test_serial_port_irq_flags_enables;
  import serial_port_irq_pkg::*;
  localparam logic [15:0] LIM = 16'h0010;
  logic ref_clk_in, rst_in, hsel_in, hwrite_in, hready_in, rdy_s;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd_s, v, m;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in, rx_samples_in;
  logic hreadyout_out, hresp_out, rx_samples_valid_in, abd_measure_in;
  logic rx_bit_out, rx_bit_valid_out, sync_mode_out, autobaud_en_out;
  logic irq_out;
  logic [15:0] abd_count_out;
  port_events_t events_in;
  int fails, n_compared;
  int bits[12] = '{0, 2, 3, 5, 6, 8, 11, 12, 13, 14, 15, 16};
  int evx[12] = '{0, 2, 3, 5, 6, 7, 9, 10, 11, 12, 0, 0};
  assign hready_in = hreadyout_out;
  serial_port_irq_flags_enables #(.BRG_LIMIT(LIM))
    serial_port_irq_flags_enables_i (.ref_clk_in, .rst_in, .hsel_in,
    .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in,
    .hrdata_out, .hreadyout_out, .hresp_out, .events_in, .rx_samples_in,
    .rx_samples_valid_in, .abd_measure_in, .rx_bit_out, .rx_bit_valid_out,
    .sync_mode_out, .autobaud_en_out, .abd_count_out, .irq_out);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in)
  begin
    rdy_s <= hreadyout_out;
    rd_s <= hrdata_out;
  end
  task check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // a stuck slave would hang the bench, so each wait is capped
  task wait_rdy;
    int n;
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end
    while (rdy_s !== 1'b1 && n < 40);
    if (rdy_s !== 1'b1)
    begin
      fails++;
      close_out;
    end
  endtask
  task xfer(input logic [31:0] a, d, input logic w);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= 2'b10;
    hwrite_in <= w;
    wait_rdy;
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    wait_rdy;
    v = rd_s;
  endtask
  task wr(input logic [31:0] a, d);
    xfer(a, d, 1'b1);
  endtask
  task rd(input logic [31:0] a, exp, input string nm);
    xfer(a, 32'h0, 1'b0);
    check(nm, v, exp);
  endtask
  task samp(input logic [2:0] s);
    rx_samples_in <= s;
    rx_samples_valid_in <= 1'b1;
    cyc(1);
    rx_samples_valid_in <= 1'b0;
    cyc(2);
  endtask
  task measure(input int n);
    abd_measure_in <= 1'b1;
    cyc(n);
    abd_measure_in <= 1'b0;
    cyc(3);
  endtask
  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  initial
  begin
    {rst_in, hsel_in, hwrite_in, haddr_in, hwdata_in} = {2'b10, 65'h0};
    {htrans_in, rx_samples_in, rx_samples_valid_in} = 6'h00;
    {abd_measure_in, events_in, fails, n_compared} = '0;
    hsize_in = 3'b010;
    cyc(12);
    rst_in <= 1'b0;
    cyc(1);
    rd(`SP_ENSET_ADDR, 32'h0, "enables");
    rd(`SP_STATUS_ADDR, 32'h0, "status");
    wr(`SP_ENSET_ADDR, 32'h0001f96d);
    rd(`SP_ENSET_ADDR, 32'h0001f96d, "enables");
    wr(`SP_ENSET_ADDR, 32'h0);
    rd(`SP_ENSET_ADDR, 32'h0001f96d, "enables");
    wr(`SP_ENCLR_ADDR, 32'h0001f96d);
    rd(`SP_ENSET_ADDR, 32'h0, "enables");
    wr(`SP_MODE_ADDR, 32'h2);
    rd(`SP_MODE_ADDR, 32'h2, "mode");
    check("autobaud en", autobaud_en_out, 32'h1);
    for (int k = 0; k < 12; k++)
    begin
      m = 32'h1 << bits[k];
      if (bits[k] == 15)
        samp(3'b001);
      else if (bits[k] == 16)
        measure(LIM + 2);
      else
        events_in[evx[k]] <= 1'b1;
      cyc(1);
      // pulse events last one cycle, levels stay until the enable is cleared
      if ((m[16:0] & `SP_W1C_MASK) != 17'h0)
        events_in <= '0;
      cyc(2);
      check("masked irq", irq_out, 32'h0);
      wr(`SP_ENSET_ADDR, m);
      cyc(2);
      if (bits[k] < 6)
        check("irq", irq_out, 32'h1);
      else if (bits[k] < 13)
        check("irq", irq_out, 32'h1);
      else if (bits[k] < 15)
        check("irq", irq_out, 32'h1);
      else
        check("irq", irq_out, 32'h1);
      wr(`SP_STATUS_ADDR, 32'h0);
      rd(`SP_STATUS_ADDR, m, "flag");
      wr(`SP_ENCLR_ADDR, m);
      cyc(2);
      check("cleared irq", irq_out, 32'h0);
      events_in <= '0;
      wr(`SP_STATUS_ADDR, m);
      rd(`SP_STATUS_ADDR, 32'h0, "flag");
    end
    samp(3'b111);
    check("majority bit", rx_bit_out, 32'h1);
    measure(5);
    check("abd count", abd_count_out, 32'h4);
    measure(LIM + 1);
    check("abd count", abd_count_out, LIM);
    rd(`SP_STATUS_ADDR, 32'h0, "quiet");
    wr(`SP_MODE_ADDR, 32'h1);
    check("sync mode", sync_mode_out, 32'h1);
    samp(3'b010);
    check("sync bit", rx_bit_out, 32'h1);
    rd(`SP_STATUS_ADDR, 32'h0, "sync noise");
    rd(32'h40064020, 32'h0, "unmapped");
    close_out;
  end
endmodule

// ---- verilog/serial_port_irq_flags_enables.sv ----
// Purpose: status flags, interrupt enables and irq request of a serial port
// Assumes: AHB-Lite single word transfers, synchronous inputs
// Notes: reads take one wait state, writes none; response always OKAY
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
`include "serial_port_irq_consts.svh"
module serial_port_irq_flags_enables #(
  parameter logic [15:0] BRG_LIMIT = `SP_BRG_LIMIT
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire serial_port_irq_pkg::port_events_t events_in,
  input wire logic [2:0] rx_samples_in,
  input wire logic rx_samples_valid_in,
  input wire logic abd_measure_in,
  output logic rx_bit_out,
  output logic rx_bit_valid_out,
  output logic sync_mode_out,
  output logic autobaud_en_out,
  output logic [15:0] abd_count_out,
  output logic irq_out
);
  import serial_port_irq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bus_state_t bus_state_reg;
  bus_state_t bus_state_next;
  addr_phase_t aphase_reg;
  logic [31:0] hrdata_reg;
  port_mode_t mode_reg;
  logic [`SP_FLAG_W-1:0] enable_reg;
  logic [`SP_FLAG_W-1:0] enable_next;
  logic [`SP_FLAG_W-1:0] sticky_reg;
  abd_state_t abd_state_reg;
  abd_state_t abd_state_next;
  logic [15:0] abd_cnt_reg;
  logic [15:0] abd_cnt_next;
  logic [15:0] abd_count_reg;
  logic rx_bit_reg;
  logic rx_bit_valid_reg;
  logic irq_reg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic accept;
  wire logic in_write;
  wire logic hit_mode;
  wire logic hit_status;
  wire logic hit_enset;
  wire logic hit_enclr;
  wire logic wr_mode;
  wire logic wr_status;
  wire logic wr_enset;
  wire logic wr_enclr;
  wire logic [`SP_FLAG_W-1:0] wdata_flags;

  // hsize is not decoded: every register is one whole word
  assign accept = hsel_in & htrans_in[1] & hready_in;
  assign in_write = (bus_state_reg == BUS_WRITE);
  assign hit_mode = (aphase_reg.addr == `SP_MODE_ADDR);
  assign hit_status = (aphase_reg.addr == `SP_STATUS_ADDR);
  assign hit_enset = (aphase_reg.addr == `SP_ENSET_ADDR);
  assign hit_enclr = (aphase_reg.addr == `SP_ENCLR_ADDR);
  assign wr_mode = in_write & hit_mode;
  assign wr_status = in_write & hit_status;
  assign wr_enset = in_write & hit_enset;
  assign wr_enclr = in_write & hit_enclr;
  // unused upper bits are dropped, so stray ones there do no harm
  assign wdata_flags = hwdata_in[`SP_FLAG_W-1:0];

  always_comb
  begin
    bus_state_next = bus_state_reg;
    unique case (bus_state_reg)
      BUS_IDLE, BUS_WRITE, BUS_READ_DONE:
      begin
        if (accept)
        begin
          bus_state_next = hwrite_in ? BUS_WRITE : BUS_READ_WAIT;
        end
        else
        begin
          bus_state_next = BUS_IDLE;
        end
      end
      BUS_READ_WAIT:
      begin
        bus_state_next = BUS_READ_DONE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      bus_state_reg <= BUS_IDLE;
      aphase_reg <= '0;
    end
    else
    begin
      bus_state_reg <= bus_state_next;
      if (accept)
      begin
        aphase_reg <= '{addr: haddr_in, write: hwrite_in};
      end
    end
  end

  // ----------------------------------------------------------------
  // majority sampling and noise
  // ----------------------------------------------------------------
  wire logic majority;
  wire logic disagree;
  wire logic noise_event;
  wire logic bit_value;

  assign majority = (rx_samples_in[0] & rx_samples_in[1])
    | (rx_samples_in[1] & rx_samples_in[2])
    | (rx_samples_in[0] & rx_samples_in[2]);
  // three samples either all agree or exactly one stands out
  assign disagree = (|rx_samples_in) & ~(&rx_samples_in);
  // sync mode is clocked by the partner, so one sample is exact
  assign bit_value = mode_reg.sync_mode ? rx_samples_in[1] : majority;
  assign noise_event = rx_samples_valid_in & disagree
    & ~mode_reg.sync_mode;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      rx_bit_reg <= 1'b1;
      rx_bit_valid_reg <= 1'b0;
    end
    else
    begin
      rx_bit_valid_reg <= rx_samples_valid_in;
      if (rx_samples_valid_in)
      begin
        rx_bit_reg <= bit_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // autobaud time-out
  // ----------------------------------------------------------------
  logic abd_error_event;

  always_comb
  begin
    abd_state_next = abd_state_reg;
    abd_cnt_next = abd_cnt_reg;
    abd_error_event = 1'b0;
    unique case (abd_state_reg)
      ABD_IDLE:
      begin
        abd_cnt_next = 16'h0000;
        if (mode_reg.autobaud_en & abd_measure_in)
        begin
          abd_state_next = ABD_COUNT;
        end
      end
      ABD_COUNT:
      begin
        if (!mode_reg.autobaud_en || !abd_measure_in)
        begin
          abd_state_next = ABD_IDLE;
        end
        else if (abd_cnt_reg == BRG_LIMIT)
        begin
          abd_error_event = 1'b1;
          abd_state_next = ABD_OVER;
        end
        else
        begin
          abd_cnt_next = abd_cnt_reg + 16'h0001;
        end
      end
      ABD_OVER:
      begin
        // one error per measured start bit, however long it lasts
        if (!mode_reg.autobaud_en || !abd_measure_in)
        begin
          abd_state_next = ABD_IDLE;
        end
      end
      default:
      begin
        abd_state_next = ABD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      abd_state_reg <= ABD_IDLE;
      abd_cnt_reg <= 16'h0000;
      abd_count_reg <= 16'h0000;
    end
    else
    begin
      abd_state_reg <= abd_state_next;
      abd_cnt_reg <= abd_cnt_next;
      if (abd_state_reg == ABD_COUNT && !abd_measure_in)
      begin
        abd_count_reg <= abd_cnt_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky flags, write one to clear
  // ----------------------------------------------------------------
  wire logic [`SP_FLAG_W-1:0] set_vec;
  wire logic [`SP_FLAG_W-1:0] clr_vec;
  wire logic [`SP_FLAG_W-1:0] status_word;
  wire logic [`SP_FLAG_W-1:0] sticky_next;
  wire logic [`SP_FLAG_W-1:0] level_vec;
  localparam logic [`SP_FLAG_W-1:0] W1C_MASK = `SP_W1C_MASK;

  assign set_vec = {abd_error_event, noise_event,
    events_in.parity_err, events_in.framing_err, events_in.start_seen,
    events_in.break_change, 2'b00, events_in.overrun, 2'b00,
    events_in.cts_change, 5'b00000};
  assign clr_vec = wr_status ? wdata_flags : '0;

  genvar gi;
  generate
    for (gi = 0; gi < `SP_FLAG_W; gi++)
    begin : g_flag
      if (W1C_MASK[gi])
      begin : g_sticky
        // a set in the clearing cycle wins, so no event is lost
        assign sticky_next[gi] = set_vec[gi]
          | (sticky_reg[gi] & ~clr_vec[gi]);
      end
      else
      begin : g_none
        assign sticky_next[gi] = 1'b0;
      end
    end
  endgenerate

  // one flop bank keeps a single driver on the whole flag vector
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sticky_reg <= '0;
    end
    else
    begin
      sticky_reg <= sticky_next;
    end
  end

  assign level_vec = {6'b000000, events_in.rx_break,
    3'b000, events_in.tx_disabled, 1'b0, events_in.cts_level,
    events_in.tx_idle, events_in.tx_ready, events_in.rx_idle,
    events_in.rx_ready};
  assign status_word = sticky_reg | level_vec;

  // ----------------------------------------------------------------
  // interrupt enables
  // ----------------------------------------------------------------
  localparam logic [`SP_FLAG_W-1:0] EN_MASK = `SP_EN_MASK;
  wire logic [`SP_FLAG_W-1:0] en_set;
  wire logic [`SP_FLAG_W-1:0] en_clr;

  assign en_set = wr_enset ? (wdata_flags & EN_MASK) : '0;
  assign en_clr = wr_enclr ? (wdata_flags & EN_MASK) : '0;
  assign enable_next = (enable_reg | en_set) & ~en_clr;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      enable_reg <= `SP_EN_RESET;
      mode_reg <= `SP_MODE_RESET;
    end
    else
    begin
      enable_reg <= enable_next;
      if (wr_mode)
      begin
        mode_reg <= '{autobaud_en: hwdata_in[`SP_MODE_ABD],
          sync_mode: hwdata_in[`SP_MODE_SYNC]};
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  wire logic [`SP_FLAG_W-1:0] pending;

  // same index for flag and enable covers rx ready through autobaud
  assign pending = status_word & enable_reg;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |pending;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire logic [31:0] status_read;
  wire logic [31:0] enable_read;
  wire logic [31:0] mode_read;
  wire logic [31:0] read_word;

  // unused upper bits read as zero rather than anything stale
  assign status_read = {15'h0, status_word};
  assign enable_read = {15'h0, enable_reg};
  assign mode_read = {30'h0, mode_reg};
  assign read_word =
    hit_status ? status_read :
    hit_enset ? enable_read :
    hit_mode ? mode_read :
    32'h00000000;

  // the wait state lets a write just before land ahead of this read
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      hrdata_reg <= 32'h00000000;
    end
    else if (bus_state_reg == BUS_READ_WAIT)
    begin
      hrdata_reg <= read_word;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata_out = hrdata_reg;
  assign hreadyout_out = (bus_state_reg != BUS_READ_WAIT);
  assign hresp_out = 1'b0;
  assign rx_bit_out = rx_bit_reg;
  assign rx_bit_valid_out = rx_bit_valid_reg;
  assign sync_mode_out = mode_reg.sync_mode;
  assign autobaud_en_out = mode_reg.autobaud_en;
  assign abd_count_out = abd_count_reg;
  assign irq_out = irq_reg;
endmodule
